// file: link_identity_config_pkg.sv
// constants and types shared by the link identity and configuration register bank
// assumes a byte-addressed register port of 11 bits and a byte-wide serial rom reader
package link_identity_config_pkg;

   // register port geometry
   localparam int          REG_ADDR_W = 11;
   localparam int          ROM_ADDR_W = 8;

   // register byte offsets
   localparam logic [10:0] OFS_SERIAL_ROM_ACCESS        = 11'h004;
   localparam logic [10:0] OFS_TRANSMIT_RETRY_LIMITS    = 11'h008;
   localparam logic [10:0] OFS_COMPARE_SWAP_NEW_VALUE   = 11'h00c;
   localparam logic [10:0] OFS_COMPARE_SWAP_EXPECTED    = 11'h010;
   localparam logic [10:0] OFS_COMPARE_SWAP_CONTROL     = 11'h014;
   localparam logic [10:0] OFS_CONFIG_ROM_FIRST_QUADLET = 11'h018;
   localparam logic [10:0] OFS_BUS_INFO_CONSTANT        = 11'h01c;
   localparam logic [10:0] OFS_BUS_CAPABILITY_OPTIONS   = 11'h020;
   localparam logic [10:0] OFS_UNIQUE_ID_UPPER          = 11'h024;
   localparam logic [10:0] OFS_UNIQUE_ID_LOWER          = 11'h028;

   // serial rom access fields
   localparam int          ROM_ADDRESS_CLEAR_BIT = 31;
   localparam int          ROM_READ_GO_BIT       = 25;
   localparam int          ROM_READ_BYTE_LSB     = 16;

   // retry limit fields
   localparam int          PHYS_RESP_RETRY_LSB  = 8;
   localparam int          ASYNC_RESP_RETRY_LSB = 4;
   localparam int          ASYNC_REQ_RETRY_LSB  = 0;
   localparam logic [11:0] RETRY_RESET          = 12'h000;

   // compare-swap control fields and resource codes
   localparam int          COMPARE_SWAP_DONE_BIT = 31;
   localparam logic        COMPARE_SWAP_DONE_RESET = 1'b1;
   localparam logic [1:0]  SEL_BUS_MANAGER_ID        = 2'h0;
   localparam logic [1:0]  SEL_BANDWIDTH_AVAILABLE   = 2'h1;
   localparam logic [1:0]  SEL_CHANNELS_AVAILABLE_HI = 2'h2;
   localparam logic [1:0]  SEL_CHANNELS_AVAILABLE_LO = 2'h3;
   localparam logic [31:0] RES_BUS_MANAGER_ID_RESET  = 32'h0000003f;
   localparam logic [31:0] RES_BANDWIDTH_RESET       = 32'h00001333;
   localparam logic [31:0] RES_CHANNELS_HI_RESET     = 32'hffffffff;
   localparam logic [31:0] RES_CHANNELS_LO_RESET     = 32'hffffffff;

   // bus information fields
   localparam logic [31:0] BUS_NAME_CONSTANT = 32'h31333934;
   localparam int          CAPS_LSB          = 27;
   localparam int          CLOCK_ACC_LSB     = 16;
   localparam int          MAX_REC_LSB       = 12;
   localparam int          GENERATION_LSB    = 6;
   localparam logic [3:0]  MAX_REC_RESET     = 4'ha;
   localparam logic [2:0]  LINK_SPEED_CODE   = 3'h2;

   // power-up rom load: byte window and where each part sits
   localparam logic [1:0]  SETTLE_LAST   = 2'h3;
   localparam logic [4:0]  BOOT_LAST     = 5'h13;
   localparam logic [4:0]  BOOT_CRC_HI   = 5'h02;
   localparam logic [4:0]  BOOT_CRC_LO   = 5'h03;
   localparam logic [4:0]  BOOT_UID_HI_0 = 5'h0c;
   localparam logic [4:0]  BOOT_UID_LO_0 = 5'h10;

   // sequencer states, one-hot
   typedef enum logic [3:0] {
      ST_SETTLE  = 4'h1,
      ST_BOOT    = 4'h2,
      ST_IDLE    = 4'h4,
      ST_SW_READ = 4'h8
   } seq_state_t;

endpackage

// file: link_identity_config_regs.sv
// link identity and configuration register bank: rom access, retry limits,
// host compare-swap on bus resources, bus info block head and unique id
// assumes rom_ack/rom_data and all register strobes come from logic on mclk;
// rom_detect is a board-level level and is synchronised here
//
// Function
// R1 - address clear bit zeroes the rom byte address, then drops itself
// R2 - read go bit fetches current rom byte, drops when byte arrives
// R3 - last fetched rom byte readable in bits 23:16
// R4 - software uses rom access only while rom present flag is set
// R5 - dual-phase retry fields 31:16 always read zero
// R6 - bits 11:8 hold physical response retry count
// R7 - bits 7:4 hold asynchronous response retry count
// R8 - bits 3:0 hold asynchronous request retry count
// R9 - compare-swap stores new value only when resource equals expected
// R10 - done flag sets on completion, clears on any control write
// R11 - two-bit select picks one of four bus resources
// R12 - first quadlet holds info length, crc length and rom crc
// R13 - rom crc field is loaded from serial rom when present
// R14 - software keeps header and options valid while link is on
// R15 - bus info constant always reads the fixed bus name word
// R16 - options bits 31:27 are writable capability flags
// R17 - options bits 23:16 hold writable clock accuracy
// R18 - max record field resets to 2048 code, kept over soft reset
// R19 - block write longer than max record bytes is flagged
// R20 - software bumps generation bits 7:6 after rom changes
// R21 - link speed field reads fixed 010
// R22 - unique ids reset zero, rom-load or one write, then locked
// R23 - rom present flag set on detection, bus info loaded after reset
// R24 - link disconnected while link on is clear
// R25 - new rom request ignored while a rom operation is busy
`timescale 1ns/10ps

module link_identity_config_regs
   import link_identity_config_pkg::*;
(
   // clock, reset, enable
   input  wire logic        mclk,
   input  wire logic        rst_n,
   input  wire logic        ce,
   input  wire logic        soft_reset,
   // register port
   input  wire logic [10:0] reg_addr,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   input  wire logic [31:0] reg_wdata,
   output logic      [31:0] reg_rdata,
   output logic             reg_rvalid,
   // serial rom byte reader
   input  wire logic        rom_detect,
   output logic             rom_req,
   output logic      [7:0]  rom_addr,
   input  wire logic        rom_ack,
   input  wire logic [7:0]  rom_data,
   output logic             rom_present_flag,
   // link control and packet checks
   input  wire logic        link_on,
   output logic             link_connected,
   input  wire logic        rx_block_valid,
   input  wire logic [15:0] rx_block_len,
   output logic             rx_too_long,
   // retry limits
   output logic      [3:0]  phys_response_retry_count,
   output logic      [3:0]  async_response_retry_count,
   output logic      [3:0]  async_request_retry_count,
   // bus info block and resources toward the serial bus side
   output logic      [31:0] config_rom_header,
   output logic      [31:0] bus_options,
   output logic      [31:0] unique_id_hi,
   output logic      [31:0] unique_id_lo,
   output logic      [31:0] bus_manager_id,
   output logic      [31:0] bandwidth_available,
   output logic      [31:0] channels_available_hi,
   output logic      [31:0] channels_available_lo
);

   typedef struct packed {
      logic             det_s1;
      logic             det_s2;
      seq_state_t       seq;
      logic [1:0]       settle;
      logic [4:0]       boot_idx;
      logic [7:0]       rom_byte_addr;
      logic             rom_address_clear;
      logic             rom_read_go;
      logic [7:0]       rom_read_byte;
      logic [11:0]      retry;
      logic [31:0]      cs_new;
      logic [31:0]      cs_expected;
      logic             compare_swap_done;
      logic [1:0]       compare_swap_resource_select;
      logic             cs_go;
      logic [3:0][31:0] res;
      logic [31:0]      header;
      logic [4:0]       caps;
      logic [7:0]       clock_acc;
      logic [3:0]       max_rec;
      logic [1:0]       generation;
      logic [31:0]      uid_hi;
      logic [31:0]      uid_lo;
      logic             uid_hi_lock;
      logic             uid_lo_lock;
      logic [31:0]      rdata;
      logic             rvalid;
      logic             link_q;
      logic             too_long;
   } regs_t;

   // fields not named here reset to zero
   localparam regs_t REGS_RESET = '{
      seq: ST_SETTLE,
      retry: RETRY_RESET,
      compare_swap_done: COMPARE_SWAP_DONE_RESET,
      compare_swap_resource_select: SEL_BUS_MANAGER_ID,
      res: {RES_CHANNELS_LO_RESET, RES_CHANNELS_HI_RESET, RES_BANDWIDTH_RESET, RES_BUS_MANAGER_ID_RESET},
      max_rec: MAX_REC_RESET,
      default: '0
   };

   regs_t s;
   regs_t next_s;

   // read mux, unmapped and reserved bits read zero
   function automatic logic [31:0] read_word(input regs_t st, input logic [10:0] a);
      logic [31:0] w;
      w = 32'h00000000;
      unique case (a)
         OFS_SERIAL_ROM_ACCESS: begin
            w[ROM_ADDRESS_CLEAR_BIT] = st.rom_address_clear;
            w[ROM_READ_GO_BIT] = st.rom_read_go;
            // R3 last rom byte
            w[ROM_READ_BYTE_LSB +: 8] = st.rom_read_byte;
         end
         OFS_TRANSMIT_RETRY_LIMITS: begin
            // R5 dual-phase fields zero
            w[11:0] = st.retry;
         end
         OFS_COMPARE_SWAP_NEW_VALUE: w = st.cs_new;
         OFS_COMPARE_SWAP_EXPECTED: w = st.cs_expected;
         OFS_COMPARE_SWAP_CONTROL: begin
            w[COMPARE_SWAP_DONE_BIT] = st.compare_swap_done;
            w[1:0] = st.compare_swap_resource_select;
         end
         OFS_CONFIG_ROM_FIRST_QUADLET: w = st.header;
         OFS_BUS_INFO_CONSTANT: begin
            // R15 fixed bus name
            w = BUS_NAME_CONSTANT;
         end
         OFS_BUS_CAPABILITY_OPTIONS: begin
            w[CAPS_LSB +: 5] = st.caps;
            w[CLOCK_ACC_LSB +: 8] = st.clock_acc;
            w[MAX_REC_LSB +: 4] = st.max_rec;
            w[GENERATION_LSB +: 2] = st.generation;
            // R21 fixed link speed
            w[2:0] = LINK_SPEED_CODE;
         end
         OFS_UNIQUE_ID_UPPER: w = st.uid_hi;
         OFS_UNIQUE_ID_LOWER: w = st.uid_lo;
         default: begin
            w = 32'h00000000;
         end
      endcase
      return w;
   endfunction

   // largest accepted block length in bytes, 2 to the power max_rec plus one
   logic [16:0] max_rec_bytes;
   assign max_rec_bytes = 17'(17'h00001 << ({1'b0, s.max_rec} + 5'h01));

   // next-state logic for the whole bank
   always_comb begin
      next_s = s;
      next_s.rvalid = 1'b0;
      next_s.too_long = 1'b0;
      // two-flop synchroniser for the rom strap
      next_s.det_s1 = rom_detect;
      next_s.det_s2 = s.det_s1;
      // R24 link disconnect
      next_s.link_q = link_on;

      // register reads answer one cycle later
      if (reg_rd) begin
         next_s.rvalid = 1'b1;
         next_s.rdata = read_word(s, reg_addr);
      end

      // register writes
      if (reg_wr) begin
         unique case (reg_addr)
            OFS_SERIAL_ROM_ACCESS: begin
               // R25 busy requests ignored
               if (s.seq == ST_IDLE && !s.rom_address_clear && !s.rom_read_go) begin
                  if (reg_wdata[ROM_ADDRESS_CLEAR_BIT]) begin
                     next_s.rom_address_clear = 1'b1;
                  end else if (reg_wdata[ROM_READ_GO_BIT]) begin
                     next_s.rom_read_go = 1'b1;
                  end
               end
            end
            OFS_TRANSMIT_RETRY_LIMITS: begin
               // R6 physical response retries
               next_s.retry[PHYS_RESP_RETRY_LSB +: 4] = reg_wdata[PHYS_RESP_RETRY_LSB +: 4];
               // R7 async response retries
               next_s.retry[ASYNC_RESP_RETRY_LSB +: 4] = reg_wdata[ASYNC_RESP_RETRY_LSB +: 4];
               // R8 async request retries
               next_s.retry[ASYNC_REQ_RETRY_LSB +: 4] = reg_wdata[ASYNC_REQ_RETRY_LSB +: 4];
            end
            OFS_COMPARE_SWAP_NEW_VALUE: begin
               next_s.cs_new = reg_wdata;
            end
            OFS_COMPARE_SWAP_EXPECTED: begin
               next_s.cs_expected = reg_wdata;
            end
            OFS_COMPARE_SWAP_CONTROL: begin
               // R10 done clears on write
               next_s.compare_swap_done = 1'b0;
               // R11 resource select
               next_s.compare_swap_resource_select = reg_wdata[1:0];
               next_s.cs_go = 1'b1;
            end
            OFS_CONFIG_ROM_FIRST_QUADLET: begin
               // R12 header fields writable
               next_s.header = reg_wdata;
            end
            OFS_BUS_CAPABILITY_OPTIONS: begin
               // R16 capability flags
               next_s.caps = reg_wdata[CAPS_LSB +: 5];
               // R17 clock accuracy
               next_s.clock_acc = reg_wdata[CLOCK_ACC_LSB +: 8];
               next_s.max_rec = reg_wdata[MAX_REC_LSB +: 4];
               next_s.generation = reg_wdata[GENERATION_LSB +: 2];
            end
            OFS_UNIQUE_ID_UPPER: begin
               // R22 write once
               if (!s.uid_hi_lock) begin
                  next_s.uid_hi = reg_wdata;
                  next_s.uid_hi_lock = 1'b1;
               end
            end
            OFS_UNIQUE_ID_LOWER: begin
               // R22 write once
               if (!s.uid_lo_lock) begin
                  next_s.uid_lo = reg_wdata;
                  next_s.uid_lo_lock = 1'b1;
               end
            end
            default: begin
               next_s.rvalid = next_s.rvalid;
            end
         endcase
      end

      // rom sequencer: power-up load, address clear, software byte read
      unique case (s.seq)
         ST_SETTLE: begin
            next_s.settle = s.settle + 2'h1;
            if (s.settle == SETTLE_LAST) begin
               // R23 load after hard reset
               if (s.det_s2) begin
                  next_s.seq = ST_BOOT;
                  next_s.boot_idx = 5'h00;
                  next_s.rom_byte_addr = 8'h00;
               end else begin
                  next_s.seq = ST_IDLE;
               end
            end
         end
         ST_BOOT: begin
            if (rom_ack) begin
               next_s.rom_byte_addr = s.rom_byte_addr + 8'h01;
               next_s.boot_idx = s.boot_idx + 5'h01;
               // R13 crc from rom
               if (s.boot_idx == BOOT_CRC_HI || s.boot_idx == BOOT_CRC_LO) begin
                  next_s.header[15:0] = {s.header[7:0], rom_data};
               end
               // R22 ids from rom
               if (s.boot_idx >= BOOT_UID_HI_0 && s.boot_idx < BOOT_UID_LO_0) begin
                  next_s.uid_hi = {s.uid_hi[23:0], rom_data};
               end
               if (s.boot_idx >= BOOT_UID_LO_0) begin
                  next_s.uid_lo = {s.uid_lo[23:0], rom_data};
               end
               if (s.boot_idx == BOOT_LAST) begin
                  // R22 lock after load
                  next_s.uid_hi_lock = 1'b1;
                  next_s.uid_lo_lock = 1'b1;
                  next_s.seq = ST_IDLE;
               end
            end
         end
         ST_IDLE: begin
            if (s.rom_address_clear) begin
               // R1 address to zero
               next_s.rom_byte_addr = 8'h00;
               next_s.rom_address_clear = 1'b0;
            end else if (s.rom_read_go) begin
               next_s.seq = ST_SW_READ;
            end
         end
         ST_SW_READ: begin
            if (rom_ack) begin
               // R2 read go drops
               next_s.rom_read_byte = rom_data;
               next_s.rom_read_go = 1'b0;
               next_s.rom_byte_addr = s.rom_byte_addr + 8'h01;
               next_s.seq = ST_IDLE;
            end
         end
         default: begin
            next_s.seq = ST_IDLE;
         end
      endcase

      // compare-swap runs the cycle after the control write; set beats clear
      if (s.cs_go) begin
         next_s.cs_go = 1'b0;
         // R10 done on completion
         next_s.compare_swap_done = 1'b1;
         // R9 swap only on match
         if (s.res[s.compare_swap_resource_select] == s.cs_expected) begin
            next_s.res[s.compare_swap_resource_select] = s.cs_new;
         end
      end

      // R19 oversize block flag
      if (rx_block_valid && ({1'b0, rx_block_len} > max_rec_bytes)) begin
         next_s.too_long = 1'b1;
      end

      // soft reset: retry, compare-swap control, caps, clock accuracy and generation back to reset values; max record, header, ids and resources kept
      if (soft_reset) begin
         next_s.retry = RETRY_RESET;
         next_s.compare_swap_done = COMPARE_SWAP_DONE_RESET;
         next_s.compare_swap_resource_select = SEL_BUS_MANAGER_ID;
         next_s.cs_go = 1'b0;
         next_s.caps = 5'h00;
         next_s.clock_acc = 8'h00;
         next_s.generation = 2'h0;
         // R18 max record kept
         next_s.max_rec = s.max_rec;
      end
   end

   // state register, frozen while ce is low
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         // R18 hard reset code
         s <= REGS_RESET;
      end else if (ce) begin
         s <= next_s;
      end
   end

   // outputs
   assign reg_rdata = s.rdata;
   assign reg_rvalid = s.rvalid;
   assign rom_req = (s.seq == ST_BOOT) || (s.seq == ST_SW_READ);
   assign rom_addr = s.rom_byte_addr;
   // R23 rom present flag
   assign rom_present_flag = s.det_s2;
   assign link_connected = s.link_q;
   assign rx_too_long = s.too_long;
   assign phys_response_retry_count = s.retry[PHYS_RESP_RETRY_LSB +: 4];
   assign async_response_retry_count = s.retry[ASYNC_RESP_RETRY_LSB +: 4];
   assign async_request_retry_count = s.retry[ASYNC_REQ_RETRY_LSB +: 4];
   assign config_rom_header = s.header;
   assign bus_options = {s.caps, 3'h0, s.clock_acc, s.max_rec, 4'h0, s.generation, 3'h0, LINK_SPEED_CODE};
   assign unique_id_hi = s.uid_hi;
   assign unique_id_lo = s.uid_lo;
   assign bus_manager_id = s.res[SEL_BUS_MANAGER_ID];
   assign bandwidth_available = s.res[SEL_BANDWIDTH_AVAILABLE];
   assign channels_available_hi = s.res[SEL_CHANNELS_AVAILABLE_HI];
   assign channels_available_lo = s.res[SEL_CHANNELS_AVAILABLE_LO];

endmodule

// file: link_identity_config_assertions.sv
// checker for the link identity register bank, watching its ports only
// assumes one mclk domain and a synchronous active-low reset
`timescale 1ns/10ps
module link_identity_config_assertions
   import link_identity_config_pkg::*;
(
   // clock, reset, enable
   input wire logic        mclk,
   input wire logic        rst_n,
   input wire logic        ce,
   input wire logic        soft_reset,
   // register port
   input wire logic [10:0] reg_addr,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [31:0] reg_wdata,
   input wire logic [31:0] reg_rdata,
   // rom reader, link, packet check
   input wire logic        rom_req,
   input wire logic [7:0]  rom_addr,
   input wire logic        rom_ack,
   input wire logic        link_on,
   input wire logic        link_connected,
   input wire logic        rx_block_valid,
   input wire logic [15:0] rx_block_len,
   input wire logic        rx_too_long,
   // configuration outputs
   input wire logic [31:0] bus_options,
   input wire logic [3:0]  phys_response_retry_count,
   input wire logic [3:0]  async_response_retry_count,
   input wire logic [3:0]  async_request_retry_count
);
   logic too_long_c;
   // length limit is two to the power of max record plus one
   assign too_long_c = 17'(rx_block_len) > (17'h1 << (5'(bus_options[15:12]) + 5'h1));

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   a_bus_name_read: assert property (ce && reg_rd && reg_addr == OFS_BUS_INFO_CONSTANT
      |=> reg_rdata == BUS_NAME_CONSTANT) else $error("bus name word wrong");
   a_dual_phase_zero: assert property (ce && reg_rd && reg_addr == OFS_TRANSMIT_RETRY_LIMITS
      |=> reg_rdata[31:16] == 16'h0000) else $error("dual phase fields not zero");
   a_link_speed_code: assert property (ce && reg_rd && reg_addr == OFS_BUS_CAPABILITY_OPTIONS
      |=> reg_rdata[2:0] == LINK_SPEED_CODE) else $error("link speed code wrong");
   a_phys_retry_write: assert property (ce && !soft_reset && reg_wr && reg_addr == OFS_TRANSMIT_RETRY_LIMITS
      |=> phys_response_retry_count == $past(reg_wdata[11:8])) else $error("phys retry not written");
   a_resp_retry_write: assert property (ce && !soft_reset && reg_wr && reg_addr == OFS_TRANSMIT_RETRY_LIMITS
      |=> async_response_retry_count == $past(reg_wdata[7:4])) else $error("resp retry not written");
   a_req_retry_write: assert property (ce && !soft_reset && reg_wr && reg_addr == OFS_TRANSMIT_RETRY_LIMITS
      |=> async_request_retry_count == $past(reg_wdata[3:0])) else $error("req retry not written");
   a_link_follows: assert property (ce ##1 ce |-> link_connected == $past(link_on))
      else $error("link connection does not follow enable");
   a_rom_addr_step: assert property (ce && rom_req && rom_ack
      |=> rom_addr == 8'($past(rom_addr) + 8'h01)) else $error("rom address did not step");
   a_block_too_long: assert property (ce && rx_block_valid
      |=> rx_too_long == $past(too_long_c)) else $error("block length flag wrong");
endmodule

// file: serial_rom_model.sv
// serial rom byte reader model: byte at address a reads as a xor a5
// assumes fetch requests from the bank on mclk; acknowledge is a one-cycle pulse
`timescale 1ns/10ps
module serial_rom_model (
   // clock and reset
   input  wire logic       mclk,
   input  wire logic       rst_n,
   // fetch handshake
   input  wire logic       rom_req,
   input  wire logic [7:0] rom_addr,
   input  wire logic       slow,
   output logic            rom_ack,
   output logic      [7:0] rom_data,
   output logic            rom_detect
);
   logic [2:0] wait_cnt;
   // rom fitted, presence level steady
   assign rom_detect = 1'b1;
   // answer after a short or long wait; data toggles outside an answer
   always_ff @(posedge mclk) begin
      rom_ack <= 1'b0;
      rom_data <= ~rom_data;
      if (!rst_n) begin
         wait_cnt <= 3'h0;
         rom_data <= 8'h3c;
      end else if (rom_req && !rom_ack && wait_cnt == (slow ? 3'h4 : 3'h0)) begin
         rom_ack <= 1'b1;
         rom_data <= rom_addr ^ 8'ha5;
         wait_cnt <= 3'h0;
      end else if (rom_req && !rom_ack) begin
         wait_cnt <= wait_cnt + 3'h1;
      end
   end
endmodule

// file: tb.sv
// testbench for the link identity register bank with a serial rom model
// assumes package, bank, rom model and checker are compiled before it
`timescale 1ns/10ps
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin err_count++; \
   $display("ERROR %0t: got %h expected %h", $time, got, exp); end end
module tb;
   import link_identity_config_pkg::*;
   logic        mclk, rst_n, reg_wr, reg_rd, reg_rvalid, link_on, link_connected, slow, soft_reset;
   logic        rom_req, rom_ack, rom_detect, rom_present_flag, rx_block_valid, rx_too_long;
   logic [10:0] reg_addr;
   logic [31:0] reg_wdata, reg_rdata, config_rom_header, bus_options, unique_id_hi, unique_id_lo;
   logic [31:0] bus_manager_id, bandwidth_available, channels_available_hi, channels_available_lo;
   logic [7:0]  rom_addr, rom_data;
   logic [15:0] rx_block_len;
   logic [3:0]  phys_response_retry_count, async_response_retry_count, async_request_retry_count;
   int          err_count, total_checks;

   link_identity_config_regs u_link_identity_config_regs (.*, .ce(1'b1));
   serial_rom_model u_serial_rom_model (.*);

   // 40 mhz clock
   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end

   task automatic end_sim();
      $display("checks %0d errors %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   task automatic wr(input logic [10:0] a, input logic [31:0] v);
      @(posedge mclk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge mclk);
      reg_wr <= 1'b0;
      #1;
   endtask

   task automatic rd(input logic [10:0] a, output logic [31:0] v);
      @(posedge mclk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1;
      v = reg_rdata;
      `CHK(reg_rvalid, 1'b1)
   endtask

   task automatic rdc(input logic [10:0] a, input logic [31:0] e);
      logic [31:0] v;
      rd(a, v);
      `CHK(v, e)
   endtask

   // poll a self-clearing bit of the rom access register, bounded
   task automatic poll(input int b, output logic [31:0] v);
      v = 32'hffffffff;
      for (int i = 0; i < 40 && v[b] !== 1'b0; i++) rd(OFS_SERIAL_ROM_ACCESS, v);
      if (v[b] !== 1'b0) begin
         err_count++;
         end_sim();
      end
   endtask

   function automatic logic [31:0] res(input int s);
      case (s)
         0: return bus_manager_id;
         1: return bandwidth_available;
         2: return channels_available_hi;
         default: return channels_available_lo;
      endcase
   endfunction

   task automatic t_reset();
      rdc(OFS_BUS_INFO_CONSTANT, BUS_NAME_CONSTANT);
      wr(OFS_BUS_INFO_CONSTANT, 32'h00000000);
      rdc(OFS_BUS_INFO_CONSTANT, BUS_NAME_CONSTANT);
      rdc(OFS_BUS_CAPABILITY_OPTIONS, 32'h0000a002);
      rdc(OFS_COMPARE_SWAP_CONTROL, 32'h80000000);
      rdc(11'h02c, 32'h00000000);
      $display("test reset done");
   endtask

   task automatic t_boot();
      for (int i = 0; i < 400 && !(rom_addr === 8'h14 && rom_req === 1'b0); i++) @(posedge mclk);
      `CHK(rom_addr, 8'h14)
      `CHK(rom_present_flag, 1'b1)
      rdc(OFS_UNIQUE_ID_UPPER, 32'ha9a8abaa);
      rdc(OFS_UNIQUE_ID_LOWER, 32'hb5b4b7b6);
      `CHK(unique_id_lo, 32'hb5b4b7b6)
      rdc(OFS_CONFIG_ROM_FIRST_QUADLET, 32'h0000a7a6);
      wr(OFS_UNIQUE_ID_UPPER, 32'hffffffff);
      rdc(OFS_UNIQUE_ID_UPPER, 32'ha9a8abaa);
      $display("test boot done");
   endtask

   task automatic t_rom();
      logic [31:0] v;
      wr(OFS_SERIAL_ROM_ACCESS, 32'h80000000);
      poll(31, v);
      `CHK(rom_addr, 8'h00)
      wr(OFS_SERIAL_ROM_ACCESS, 32'h02000000);
      wr(OFS_SERIAL_ROM_ACCESS, 32'h80000000);
      poll(25, v);
      `CHK(v[23:16], 8'ha5)
      `CHK(rom_addr, 8'h01)
      wr(OFS_SERIAL_ROM_ACCESS, 32'h80000000);
      poll(31, v);
      `CHK(v[23:16], 8'ha5)
      `CHK(rom_addr, 8'h00)
      $display("test rom done");
   endtask

   task automatic t_regs();
      logic [31:0] init [4] = '{RES_BUS_MANAGER_ID_RESET, RES_BANDWIDTH_RESET, RES_CHANNELS_HI_RESET,
                                RES_CHANNELS_LO_RESET};
      wr(OFS_TRANSMIT_RETRY_LIMITS, 32'hffffffff);
      rdc(OFS_TRANSMIT_RETRY_LIMITS, 32'h00000fff);
      wr(OFS_TRANSMIT_RETRY_LIMITS, 32'h00000321);
      `CHK(phys_response_retry_count, 4'h3)
      `CHK(async_response_retry_count, 4'h2)
      `CHK(async_request_retry_count, 4'h1)
      for (int s = 0; s < 4; s++) begin
         wr(OFS_COMPARE_SWAP_EXPECTED, 32'h0bad0000);
         wr(OFS_COMPARE_SWAP_NEW_VALUE, 32'h5a000000 | 32'(s));
         wr(OFS_COMPARE_SWAP_CONTROL, 32'(s));
         rdc(OFS_COMPARE_SWAP_CONTROL, 32'h80000000 | 32'(s));
         `CHK(res(s), init[s])
         wr(OFS_COMPARE_SWAP_EXPECTED, init[s]);
         wr(OFS_COMPARE_SWAP_CONTROL, 32'(s));
         rdc(OFS_COMPARE_SWAP_CONTROL, 32'h80000000 | 32'(s));
         `CHK(res(s), 32'h5a000000 | 32'(s))
      end
      $display("test registers done");
   endtask

   task automatic rx(input logic [15:0] len, input logic e);
      @(posedge mclk);
      rx_block_valid <= 1'b1;
      rx_block_len <= len;
      @(posedge mclk);
      rx_block_valid <= 1'b0;
      #1;
      `CHK(rx_too_long, e)
   endtask

   task automatic t_link();
      rx(16'd2048, 1'b0);
      rx(16'd2049, 1'b1);
      wr(OFS_CONFIG_ROM_FIRST_QUADLET, 32'h04041234);
      rdc(OFS_CONFIG_ROM_FIRST_QUADLET, 32'h04041234);
      `CHK(config_rom_header, 32'h04041234)
      wr(OFS_BUS_CAPABILITY_OPTIONS, 32'hffffffff);
      rdc(OFS_BUS_CAPABILITY_OPTIONS, 32'hf8fff0c2);
      `CHK(bus_options, 32'hf8fff0c2)
      @(posedge mclk);
      soft_reset <= 1'b1;
      @(posedge mclk);
      soft_reset <= 1'b0;
      rdc(OFS_BUS_CAPABILITY_OPTIONS, 32'h0000f002);
      rx(16'hffff, 1'b0);
      @(posedge mclk);
      link_on <= 1'b1;
      @(posedge mclk);
      #1;
      `CHK(link_connected, 1'b1)
      $display("test link done");
   endtask

   initial begin
      rst_n = 1'b0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 11'h000;
      reg_wdata = 32'h00000000;
      link_on = 1'b0;
      rx_block_valid = 1'b0;
      rx_block_len = 16'h0000;
      slow = 1'b1;
      soft_reset = 1'b0;
      err_count = 0;
      total_checks = 0;
      repeat (6) @(posedge mclk);
      rst_n <= 1'b1;
      t_reset();
      t_boot();
      t_rom();
      t_regs();
      t_link();
      end_sim();
   end
endmodule

bind link_identity_config_regs link_identity_config_assertions u_link_identity_config_assertions (.*);
